// ===== e3w_port.sv
// Purpose: Serial front end and control of a three-wire serial EEPROM.
// Assumes: Pins are asynchronous; serial clock is far slower than sys_clk.
// Notes: Pin-side pull-up of the strap and tri-state resolution sit outside.
`include "e3w_defs.svh"

module e3w_port #(
    parameter bit FIXED_X16 = 1'b0,
    parameter int unsigned WRITE_CYCLES = `E3W_WRITE_CYCLES
) (
    // Clock, reset and enable
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    // Serial pins in
    input wire e3w_pkg::e3w_pins_t pins,
    // Serial data out with its enable
    output e3w_pkg::e3w_dout_t dout
);
    import e3w_pkg::*;

    localparam logic [`E3W_BUSY_W-1:0] WR_CYC = `E3W_BUSY_W'(WRITE_CYCLES);

    e3w_core_t r;
    e3w_core_t n;
    e3w_pins_t p;
    logic [`E3W_WORD_W-1:0] rd_data;
    logic [`E3W_WIDX_W-1:0] rd_word;
    logic sk_rise;
    logic cs_fall;
    logic busy;
    logic start_ok;
    logic hdr_last;
    logic [`E3W_HDR_W-1:0] hdr_full;
    logic [1:0] op;
    logic [1:0] sub;
    logic [`E3W_ADDR_W-1:0] a;
    logic [`E3W_WORD_W-1:0] out_word;

    function automatic logic [`E3W_CNT_W-1:0] dbits(input logic x16);
        return x16 ? `E3W_DBITS_X16 : `E3W_DBITS_X8;
    endfunction : dbits

    function automatic logic [`E3W_CNT_W-1:0] abits(input logic x16);
        return x16 ? `E3W_ABITS_X16 : `E3W_ABITS_X8;
    endfunction : abits

    function automatic logic [`E3W_WIDX_W-1:0] widx(input logic x16,
                                                   input logic [`E3W_ADDR_W-1:0] ad);
        return x16 ? ad[5:0] : ad[6:1];
    endfunction : widx

    e3w_sync #(
        .W(4)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .d(pins),
        .q(p)
    );

    e3w_array #(
        .WORDS(`E3W_WORDS)
    ) u_array (
        .sys_clk(sys_clk),
        .ce(ce),
        .rd_word(rd_word),
        .rd_data(rd_data),
        .wr(r.wr)
    );

    assign rd_word = widx(r.x16, r.addr);
    assign sk_rise = p.sk & ~r.sk_prev;
    assign cs_fall = ~p.cs & r.cs_prev;
    assign busy = (r.busy_cnt != '0);
    assign start_ok = (r.st == ST_IDLE) && p.si && !busy;
    assign hdr_last = (r.st == ST_HDR) && (r.cnt == abits(r.x16) + `E3W_CNT_W'(1));
    assign hdr_full = {r.hdr[`E3W_HDR_W-2:0], p.si};
    assign op = r.x16 ? hdr_full[7:6] : hdr_full[8:7];
    assign a = r.x16 ? {1'b0, hdr_full[5:0]} : hdr_full[6:0];
    assign sub = r.x16 ? hdr_full[5:4] : hdr_full[6:5];
    // In 8-bit mode the byte is moved to the top so the outgoing bit is always bit 15.
    assign out_word = (r.cnt != '0) ? r.shreg :
                      r.x16 ? rd_data :
                      r.addr[0] ? {rd_data[15:8], 8'h00} : {rd_data[7:0], 8'h00};

    always_comb begin
        n = r;
        n.wr.we = 1'b0;
        n.sk_prev = p.sk;
        n.cs_prev = p.cs;
        if (busy) begin
            n.busy_cnt = r.busy_cnt - `E3W_BUSY_W'(1);
        end
        if (!p.cs) begin
            // Deselected: drop any partial frame and release the output.
            n.st = ST_IDLE;
            n.cnt = '0;
            n.dout.en = 1'b0;
            n.dout.data = 1'b0;
            n.frame_ok = 1'b0;
            // The write is launched by the deselect that ends its frame.
            if (cs_fall && r.frame_ok && r.wr_en && !busy) begin
                n.wr.we = 1'b1;
                n.wr.all = r.all;
                n.wr.word = widx(r.x16, r.addr);
                n.wr.lanes = r.x16 ? 2'h3 : (r.addr[0] ? 2'h2 : 2'h1);
                n.wr.data = r.erase ? `E3W_ERASED_WORD :
                            r.x16 ? r.shreg : {r.shreg[7:0], r.shreg[7:0]};
                n.busy_cnt = WR_CYC;
                n.status_pend = 1'b1;
            end
        end else begin
            if ((r.st == ST_IDLE) && r.status_pend) begin
                n.dout.en = 1'b1;
                n.dout.data = !busy;
            end
            if (sk_rise) begin
                unique case (r.st)
                    ST_IDLE: begin
                        // A start bit is refused while the timed write runs.
                        if (start_ok) begin
                            n.st = ST_HDR;
                            n.cnt = '0;
                            n.x16 = FIXED_X16 | p.organization_strap;
                            n.status_pend = 1'b0;
                            n.dout.en = 1'b0;
                        end
                    end
                    ST_HDR: begin
                        n.hdr = hdr_full;
                        n.cnt = r.cnt + `E3W_CNT_W'(1);
                        if (hdr_last) begin
                            n.cnt = '0;
                            n.addr = a;
                            n.all = 1'b0;
                            n.erase = 1'b0;
                            n.st = ST_HOLD;
                            unique case (op)
                                `E3W_OP_READ: begin
                                    n.st = ST_READ;
                                    n.dout.en = 1'b1;
                                    n.dout.data = 1'b0;
                                end
                                `E3W_OP_WRITE: begin
                                    n.st = ST_WDATA;
                                end
                                `E3W_OP_ERASE: begin
                                    n.erase = 1'b1;
                                    n.frame_ok = 1'b1;
                                end
                                `E3W_OP_EXT: begin
                                    unique case (sub)
                                        `E3W_EXT_EN: n.wr_en = 1'b1;
                                        `E3W_EXT_DIS: n.wr_en = 1'b0;
                                        `E3W_EXT_WRALL: begin
                                            n.all = 1'b1;
                                            n.st = ST_WDATA;
                                        end
                                        `E3W_EXT_ERALL: begin
                                            n.all = 1'b1;
                                            n.erase = 1'b1;
                                            n.frame_ok = 1'b1;
                                        end
                                    endcase
                                end
                            endcase
                        end
                    end
                    ST_WDATA: begin
                        n.shreg = {r.shreg[`E3W_WORD_W-2:0], p.si};
                        n.cnt = r.cnt + `E3W_CNT_W'(1);
                        if (r.cnt == dbits(r.x16) - `E3W_CNT_W'(1)) begin
                            n.frame_ok = 1'b1;
                            n.st = ST_HOLD;
                        end
                    end
                    ST_READ: begin
                        n.dout.data = out_word[`E3W_WORD_W-1];
                        n.shreg = {out_word[`E3W_WORD_W-2:0], 1'b0};
                        n.cnt = r.cnt + `E3W_CNT_W'(1);
                        // Reads run on into the next word until deselected.
                        if (r.cnt == dbits(r.x16) - `E3W_CNT_W'(1)) begin
                            n.cnt = '0;
                            n.addr = r.x16 ? {1'b0, r.addr[5:0] + 6'h01} :
                                             r.addr + `E3W_ADDR_W'(1);
                        end
                    end
                    ST_HOLD: begin
                        n.frame_ok = r.frame_ok;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            r <= '0;
            r.st <= ST_IDLE;
            r.wr_en <= `E3W_RST_WR_EN;
        end else if (ce) begin
            r <= n;
        end
    end

    assign dout = r.dout;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence s_start;
        ce && p.cs && sk_rise && start_ok;
    endsequence

    sequence s_read_decoded;
        ce && p.cs && sk_rise && hdr_last && (op == `E3W_OP_READ);
    endsequence

    property p_desel_hiz;
        ce && !p.cs |=> !dout.en;
    endproperty
    a_desel_hiz: assert property (p_desel_hiz) else $error("output driven while deselected");

    property p_desel_restart;
        ce && !p.cs |=> (r.st == ST_IDLE) && (r.cnt == '0) && !r.frame_ok;
    endproperty
    a_desel_restart: assert property (p_desel_restart) else $error("frame kept over deselect");

    property p_capture;
        ce && p.cs && sk_rise && (r.st == ST_HDR) |=> r.hdr[0] == $past(p.si);
    endproperty
    a_capture: assert property (p_capture) else $error("header bit not captured");

    property p_read_dummy;
        s_read_decoded |=> (r.st == ST_READ) && dout.en && !dout.data && (r.cnt == '0);
    endproperty
    a_read_dummy: assert property (p_read_dummy) else $error("read did not start");

    property p_read_shift;
        ce && p.cs && sk_rise && (r.st == ST_READ) |=> dout.data == $past(out_word[15]) && dout.en;
    endproperty
    a_read_shift: assert property (p_read_shift) else $error("read bit wrong");

    property p_status;
        ce && p.cs && (r.st == ST_IDLE) && r.status_pend && !sk_rise |=>
            dout.en && (dout.data == $past(!busy));
    endproperty
    a_status: assert property (p_status) else $error("ready/busy not shown");

    property p_org;
        s_start |=> (r.x16 == $past(FIXED_X16 | p.organization_strap)) && (r.st == ST_HDR);
    endproperty
    a_org: assert property (p_org) else $error("organization not taken");

    property p_write_timed;
        r.wr.we |-> (r.busy_cnt == WR_CYC) && r.status_pend && (r.busy_cnt <= WR_CYC);
    endproperty
    a_write_timed: assert property (p_write_timed) else $error("write timer not loaded");

    property p_write_enabled;
        r.wr.we |-> $past(r.wr_en) && $past(r.frame_ok);
    endproperty
    a_write_enabled: assert property (p_write_enabled) else $error("write while disabled");

    property p_busy_refuse;
        ce && p.cs && sk_rise && busy && (r.st == ST_IDLE) |=> (r.st == ST_IDLE);
    endproperty
    a_busy_refuse: assert property (p_busy_refuse) else $error("start taken while busy");
endmodule : e3w_port

// ===== e3w_defs.svh
// Purpose: Constants of the three-wire serial EEPROM port: widths, opcodes, timing, reset values.
// Assumes: Included by bare name from the package, the port, the array, the host and the bench.
// Notes: Widths, opcodes, counts, write timing and the write-enable reset value live here as macros; bit positions are written in the modules.
//
// Notes on behaviour
// - The port is selected only while chip select is high.
// - While deselected, serial input is ignored; no bit is taken.
// - While deselected, the serial output is released to high impedance.
// - Instruction, address and data bits are captured on rising serial clock edges.
// - Read data changes after each rising serial clock, one bit per clock.
// - A read decodes its address, then shifts the addressed word out.
// - Chip select raised after a started write shows ready/busy on the output.
// - Strap high selects 64 words of 16 bits.
// - Strap low selects 128 words of 8 bits.
// - A floating strap is pulled up and selects the 16-bit organization.
// - The array holds 1024 bits, as 64x16 or 128x8.
// - The fixed variant has no strap and always runs 64x16.
// - A write is self-timed and overwrites without a prior erase.
// - The timed write and its busy indication last at most 5 ms.
// - A write starts only in the erase/write enable state.
`ifndef E3W_DEFS_SVH
`define E3W_DEFS_SVH

`define E3W_SYS_CLK_PERIOD_NS 8
`define E3W_WRITE_TIME_MS 5
`define E3W_WRITE_CYCLES (`E3W_WRITE_TIME_MS * 1000000 / `E3W_SYS_CLK_PERIOD_NS)
`define E3W_BUSY_W 20
`define E3W_WORDS 64
`define E3W_WORD_W 16
`define E3W_WIDX_W 6
`define E3W_ADDR_W 7
`define E3W_HDR_W 9
`define E3W_CNT_W 5
`define E3W_ABITS_X16 5'h06
`define E3W_ABITS_X8 5'h07
`define E3W_DBITS_X16 5'h10
`define E3W_DBITS_X8 5'h08
`define E3W_OP_EXT 2'h0
`define E3W_OP_WRITE 2'h1
`define E3W_OP_READ 2'h2
`define E3W_OP_ERASE 2'h3
`define E3W_EXT_DIS 2'h0
`define E3W_EXT_WRALL 2'h1
`define E3W_EXT_ERALL 2'h2
`define E3W_EXT_EN 2'h3
`define E3W_ERASED_WORD 16'hFFFF
`define E3W_RST_WR_EN 1'h0

`endif

// ===== e3w_pkg.sv
// Purpose: Types shared by the serial EEPROM port modules.
// Assumes: e3w_defs.svh supplies the widths.
// Notes: Only types live here; numbers stay in the header.
`include "e3w_defs.svh"

package e3w_pkg;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_HDR = 5'h02,
        ST_WDATA = 5'h04,
        ST_READ = 5'h08,
        ST_HOLD = 5'h10
    } e3w_state_t;

    typedef struct packed {
        logic cs;
        logic sk;
        logic si;
        logic organization_strap;
    } e3w_pins_t;

    typedef struct packed {
        logic data;
        logic en;
    } e3w_dout_t;

    typedef struct packed {
        logic we;
        logic all;
        logic [`E3W_WIDX_W-1:0] word;
        logic [1:0] lanes;
        logic [`E3W_WORD_W-1:0] data;
    } e3w_wr_t;

    typedef struct packed {
        e3w_state_t st;
        logic sk_prev;
        logic cs_prev;
        logic x16;
        logic [`E3W_HDR_W-1:0] hdr;
        logic [`E3W_CNT_W-1:0] cnt;
        logic [`E3W_WORD_W-1:0] shreg;
        logic [`E3W_ADDR_W-1:0] addr;
        logic all;
        logic erase;
        logic frame_ok;
        logic wr_en;
        logic [`E3W_BUSY_W-1:0] busy_cnt;
        logic status_pend;
        e3w_dout_t dout;
        e3w_wr_t wr;
    } e3w_core_t;

endpackage : e3w_pkg

// ===== e3w_sync.sv
// Purpose: Two-stage synchroniser for the serial pins.
// Assumes: Inputs are asynchronous to sys_clk.
// Notes: Only the second stage is visible outside.
module e3w_sync #(
    parameter int W = 4
) (
    // Clock, reset and enable
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [1:0][W-1:0] s_r;
    logic [1:0][W-1:0] s_nxt;

    always_comb begin
        s_nxt = {s_r[0], d};
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r[1];
endmodule : e3w_sync

// ===== e3w_array.sv
// Purpose: 1024-bit storage, 64 words of 16 bits with byte lanes.
// Assumes: One write request per cycle, asynchronous read.
// Notes: No reset on contents, as a nonvolatile array keeps them.
`include "e3w_defs.svh"

module e3w_array #(
    parameter int WORDS = `E3W_WORDS
) (
    // Clock and enable
    input wire logic sys_clk,
    input wire logic ce,
    // Read port
    input wire logic [`E3W_WIDX_W-1:0] rd_word,
    output logic [`E3W_WORD_W-1:0] rd_data,
    // Write port
    input wire e3w_pkg::e3w_wr_t wr
);
    import e3w_pkg::*;

    logic [`E3W_WORD_W-1:0] mem [WORDS];

    assign rd_data = mem[rd_word];

    // Overwrites in place; lanes not selected keep their bits.
    always_ff @(posedge sys_clk) begin
        if (ce && wr.we) begin
            for (int i = 0; i < WORDS; i++) begin
                if (wr.all || (i == int'(wr.word))) begin
                    if (wr.lanes[1]) begin
                        mem[i][15:8] <= wr.data[15:8];
                    end
                    if (wr.lanes[0]) begin
                        mem[i][7:0] <= wr.data[7:0];
                    end
                end
            end
        end
    end
endmodule : e3w_array

// ===== e3w_host.sv
// Purpose: Behavioural serial master that drives the pins of the EEPROM port.
// Assumes: The bench calls its tasks; every pin change lands on a falling sys_clk edge.
// Notes: The serial clock runs only inside shifts, at 72 ns; the data line toggles when idle.
`include "e3w_defs.svh"

module e3w_host (
    // Clock
    input wire logic sys_clk,
    // Pins towards the port
    output logic cs,
    output logic sk,
    output logic si,
    input wire e3w_pkg::e3w_dout_t dout_in,
    // Results towards the bench
    output logic [15:0] res,
    output logic res_valid
);
    import e3w_pkg::*;

    logic shifting = 1'b0;

    initial begin
        cs = 1'b0;
        sk = 1'b0;
        si = 1'b0;
        res = 16'h0000;
        res_valid = 1'b0;
    end

    // A released data line must not look stable, so it toggles every cycle.
    always @(negedge sys_clk) begin
        if (!cs && !shifting) begin
            si <= ~si;
        end
    end

    task automatic sel(input logic on);
        @(negedge sys_clk) cs = on;
        repeat (4) @(negedge sys_clk);
    endtask : sel

    task automatic shift(input logic [47:0] b, input int n, output logic [47:0] g);
        g = '0;
        shifting = 1'b1;
        for (int i = n - 1; i >= 0; i--) begin
            @(negedge sys_clk) si = b[i];
            repeat (3) @(negedge sys_clk);
            @(negedge sys_clk) sk = 1'b1;
            repeat (3) @(negedge sys_clk);
            @(negedge sys_clk) g = {g[46:0], dout_in.data};
            sk = 1'b0;
        end
        shifting = 1'b0;
    endtask : shift

    task automatic report(input logic [15:0] v);
        @(negedge sys_clk) res = v;
        res_valid = 1'b1;
        @(negedge sys_clk) res_valid = 1'b0;
    endtask : report

    task automatic probe();
        report({14'h0000, dout_in});
    endtask : probe
endmodule : e3w_host

// ===== tb.sv
// Purpose: Self-checking bench of the serial EEPROM port and its strapless variant.
// Assumes: Host model drives the pins; results return through its report strobe.
// Notes: A short write time keeps the run brief; a second port sees the same pins.
`include "e3w_defs.svh"

module tb;
    import e3w_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int WC = 50;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic use_fixed = 1'b0;
    logic org_drv = 1'b0;
    logic org_val = 1'b1;
    logic cs, sk, si, res_valid;
    logic [15:0] res, d1, d2, d5;
    logic [5:0] a1;
    logic [47:0] junk;
    logic [31:0] seed = 32'h5C20953E;
    logic [15:0] exp_q[$];
    int fail_count = 0;
    int n_checks = 0;
    tri1 org_net;
    e3w_pins_t pins;
    e3w_dout_t dout_a, dout_b, dout_mux;

    // The pull-up sits on the net, so an undriven strap reads high.
    assign org_net = org_drv ? org_val : 1'bz;
    assign pins = {cs, sk, si, org_net};
    assign dout_mux = use_fixed ? dout_b : dout_a;
    always #4 sys_clk = ~sys_clk;

    e3w_port #(.FIXED_X16(1'b0), .WRITE_CYCLES(WC)) e3w_port_inst (.sys_clk(sys_clk),
        .rst(rst), .ce(ce), .pins(pins), .dout(dout_a));
    e3w_port #(.FIXED_X16(1'b1), .WRITE_CYCLES(WC)) e3w_port_fixed_inst (.sys_clk(sys_clk),
        .rst(rst), .ce(ce), .pins(pins), .dout(dout_b));
    e3w_host e3w_host_inst (.sys_clk(sys_clk), .cs(cs), .sk(sk), .si(si), .dout_in(dout_mux),
        .res(res), .res_valid(res_valid));

    function automatic logic [15:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction : rnd

    function automatic logic [8:0] hdr(input logic [1:0] op, input logic [5:0] a);
        return {1'b1, op, a};
    endfunction : hdr

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
            fail_count++;
        end
    endtask : check

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic note(input logic [15:0] v);
        exp_q.push_back(v);
    endtask : note

    task automatic frame(input logic [47:0] b, input int n);
        logic [47:0] g;
        e3w_host_inst.sel(1'b1);
        e3w_host_inst.shift(b, n, g);
        e3w_host_inst.sel(1'b0);
    endtask : frame

    task automatic rd(input logic [47:0] b, input int n, input int words, input logic [15:0] m);
        logic [47:0] g;
        e3w_host_inst.sel(1'b1);
        e3w_host_inst.shift(b, n, g);
        e3w_host_inst.sel(1'b0);
        for (int i = words - 1; i >= 0; i--) begin
            e3w_host_inst.report(g[i*16 +: 16] & m);
        end
    endtask : rd

    task automatic rd16(input logic [5:0] a, input logic [15:0] d);
        note(d);
        rd({23'h000000, hdr(`E3W_OP_READ, a), 16'h0000}, 25, 1, 16'hFFFF);
    endtask : rd16

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        frame({23'h000000, hdr(`E3W_OP_WRITE, a), d}, 25);
    endtask : wr

    task automatic ext(input logic [1:0] code);
        frame({39'h0000000000, hdr(`E3W_OP_EXT, {code, 4'h0})}, 9);
    endtask : ext

    task automatic wait_ready();
        note(16'h0001);
        e3w_host_inst.sel(1'b1);
        e3w_host_inst.probe();
        repeat (WC - 25) @(negedge sys_clk);
        note(16'h0001);
        e3w_host_inst.probe();
        repeat (35) @(negedge sys_clk);
        note(16'h0003);
        e3w_host_inst.probe();
        e3w_host_inst.sel(1'b0);
    endtask : wait_ready

    always @(posedge sys_clk) begin
        if (res_valid === 1'b1) begin
            check("dout_word", res, exp_q.size() > 0 ? exp_q.pop_front() : 16'hXXXX);
        end
    end

    initial begin
        repeat (16) @(negedge sys_clk);
        rst = 1'b0;
        repeat (4) @(negedge sys_clk);
        note(16'h0000);
        e3w_host_inst.probe();
        a1 = 6'(rnd());
        d1 = rnd();
        d2 = rnd();
        d5 = rnd();
        ext(`E3W_EXT_EN);
        wr(a1, d1);
        wait_ready();
        rd16(a1, d1);
        wr(a1, d2);
        wait_ready();
        rd16(a1, d2);
        $display("test write and overwrite done");
        ext(`E3W_EXT_DIS);
        wr(a1, d1);
        note(16'h0000);
        e3w_host_inst.sel(1'b1);
        e3w_host_inst.probe();
        e3w_host_inst.sel(1'b0);
        rd16(a1, d2);
        $display("test refused write done");
        ext(`E3W_EXT_EN);
        frame({39'h0000000000, hdr(`E3W_OP_ERASE, a1)}, 9);
        wait_ready();
        rd16(a1, 16'hFFFF);
        frame({23'h000000, hdr(`E3W_OP_EXT, {`E3W_EXT_WRALL, 4'h0}), d1}, 25);
        wait_ready();
        rd16(6'(rnd()), d1);
        ext(`E3W_EXT_ERALL);
        wait_ready();
        wr(6'h00, d5);
        wait_ready();
        note(16'hFFFF);
        note(d5);
        rd({7'h00, hdr(`E3W_OP_READ, 6'h3F), 32'h00000000}, 41, 2, 16'hFFFF);
        $display("test erase and sequential read done");
        // A write framed while the clock enable is low must leave no trace.
        ce = 1'b0;
        wr(6'h00, d2);
        repeat (4 + int'(rnd() & 16'h0007)) @(negedge sys_clk);
        ce = 1'b1;
        repeat (4) @(negedge sys_clk);
        rd16(6'h00, d5);
        $display("test clock enable freeze done");
        e3w_host_inst.shift({39'h0000000000, hdr(`E3W_OP_READ, 6'h00)}, 9, junk);
        note(16'h0000);
        e3w_host_inst.probe();
        e3w_host_inst.sel(1'b1);
        e3w_host_inst.shift({45'h000000000000, 3'h6}, 3, junk);
        e3w_host_inst.sel(1'b0);
        org_drv = 1'b1;
        rd16(6'h00, d5);
        $display("test deselect and abandon done");
        org_val = 1'b0;
        note({8'h00, d5[7:0]});
        rd({30'h00000000, 1'b1, `E3W_OP_READ, 7'h00, 8'h00}, 18, 1, 16'h00FF);
        note({8'h00, d5[15:8]});
        rd({30'h00000000, 1'b1, `E3W_OP_READ, 7'h01, 8'h00}, 18, 1, 16'h00FF);
        use_fixed = 1'b1;
        rd16(6'h00, d5);
        $display("test organization done");
        for (int i = 0; i < 100 && exp_q.size() > 0; i++) begin
            @(negedge sys_clk);
        end
        if (exp_q.size() > 0) begin
            fail_count++;
        end
        stop_test();
    end

    initial begin
        repeat (60000) @(posedge sys_clk);
        fail_count++;
        stop_test();
    end
endmodule : tb
